// *** verilog/atpm_pkg.sv ***
// Constants, register map and types for the amplitude threshold and peak monitor.
// Function
// - With the flag enabled, set it at once when magnitude exceeds upper threshold.
// - Clear the flag only after magnitude stays below lower threshold beyond dwell.
// - An upper threshold crossing reaches the flag pin within 28 clock cycles.
// - Compare output magnitude with the upper threshold held in two register bytes.
// - Lower threshold is 13 bits over two bytes, compared after pipeline latency.
// - Threshold values are scaled so that two to the thirteenth is full scale.
// - Dwell time is 1 to 65535 sample clocks, held in two register bytes.
// - Control bits in the flag control register turn each threshold flag on or off.
// - The peak observation period is a 24-bit count of converter output samples.
// - The peak detector tracks magnitude only and reports a 13-bit value.
// - Bit 1 of the peak monitor control register enables the peak detector.
// - On enable, load the period into a timer decrementing at the decimated rate.
// - Per sample, keep the greater of sample magnitude and the hidden store.
// - The hidden store starts each observation with the current sample magnitude.
// - When the period timer reaches 1, copy the peak into the holding register.
// - Then reload the timer, restart the countdown and seed with the next sample.
// - Each channel has its own threshold detector and its own flag pin.
package atpm_pkg;

   localparam int ATPM_SAMPLE_W = 14;
   localparam int ATPM_MAG_W = 13;
   localparam int ATPM_DWELL_W = 16;
   localparam int ATPM_PERIOD_W = 24;
   localparam int ATPM_NUM_CHAN = 2;
   localparam int ATPM_UPPER_LAT_MAX_CYC = 28;

   // Register addresses on the serial port.
   localparam logic [14:0] ATPM_ADDR_UPPER_LO = 15'h0247;
   localparam logic [14:0] ATPM_ADDR_UPPER_HI = 15'h0248;
   localparam logic [14:0] ATPM_ADDR_LOWER_LO = 15'h0249;
   localparam logic [14:0] ATPM_ADDR_LOWER_HI = 15'h024A;
   localparam logic [14:0] ATPM_ADDR_DWELL_LO = 15'h024B;
   localparam logic [14:0] ATPM_ADDR_DWELL_HI = 15'h024C;
   localparam logic [14:0] ATPM_ADDR_PEAK_CTRL = 15'h0270;
   localparam logic [14:0] ATPM_ADDR_PERIOD_0 = 15'h0271;
   localparam logic [14:0] ATPM_ADDR_PERIOD_1 = 15'h0272;
   localparam logic [14:0] ATPM_ADDR_PERIOD_2 = 15'h0273;
   localparam logic [14:0] ATPM_ADDR_HOLD_A_LO = 15'h0274;
   localparam logic [14:0] ATPM_ADDR_HOLD_A_HI = 15'h0275;
   localparam logic [14:0] ATPM_ADDR_HOLD_B_LO = 15'h0276;
   localparam logic [14:0] ATPM_ADDR_HOLD_B_HI = 15'h0277;
   localparam logic [14:0] ATPM_ADDR_FLAG_CTRL = 15'h0559;

   // Field positions.
   localparam int ATPM_FLAG_EN_A_BIT = 0;
   localparam int ATPM_FLAG_EN_B_BIT = 1;
   localparam int ATPM_PEAK_EN_BIT = 1;
   localparam int ATPM_HI_BYTE_W = 5;

   // Values after reset.
   localparam logic [7:0] ATPM_RST_BYTE = 8'h00;
   localparam logic [7:0] ATPM_RST_DWELL_LO = 8'h01;

   // Serial frame: one read/write bit, fifteen address bits, then eight data bits.
   localparam logic [3:0] ATPM_SPI_INSTR_LAST = 4'hF;
   localparam logic [3:0] ATPM_SPI_DATA_LAST = 4'h7;

   typedef enum logic [1:0] {
      ATPM_SPI_INSTR,
      ATPM_SPI_DATA,
      ATPM_SPI_DONE
   } atpm_spi_state_t;

endpackage

// *** verilog/atpm_thresh_chan.sv ***
// One channel of the threshold flag with hysteresis and dwell.
`timescale 1ns/1ps
module atpm_thresh_chan (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Magnitude and settings
   input wire logic [atpm_pkg::ATPM_MAG_W-1:0] i_mag,
   input wire logic i_enable,
   input wire logic [atpm_pkg::ATPM_MAG_W-1:0] i_upper,
   input wire logic [atpm_pkg::ATPM_MAG_W-1:0] i_lower,
   input wire logic [atpm_pkg::ATPM_DWELL_W-1:0] i_dwell,
   // Flag
   output logic o_flag
);

   logic flag_r;
   logic [atpm_pkg::ATPM_DWELL_W-1:0] dwell_cnt_r;
   logic above;
   logic below;
   logic dwell_done;

   assign above = i_mag > i_upper;
   assign below = i_mag < i_lower;
   // The count holds the below cycles already seen, so the clear needs one more than dwell.
   assign dwell_done = below && (dwell_cnt_r >= i_dwell);

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dwell_cnt_r <= '0;
      end else if (!flag_r || !below || above) begin
         dwell_cnt_r <= '0;
      end else if (dwell_cnt_r != {atpm_pkg::ATPM_DWELL_W{1'b1}}) begin
         dwell_cnt_r <= dwell_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flag_r <= 1'b0;
      end else if (!i_enable) begin
         flag_r <= 1'b0;
      end else if (above) begin
         flag_r <= 1'b1;
      end else if (flag_r && dwell_done) begin
         flag_r <= 1'b0;
      end
   end

   assign o_flag = flag_r;

   property p_set_on_upper;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_enable && above) |=> flag_r;
   endproperty
   a_set_on_upper: assert property (p_set_on_upper) else $error("flag not set on upper cross");

   property p_clear_after_dwell;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $fell(flag_r) |-> (!$past(i_enable) || $past(dwell_done));
   endproperty
   a_clear_after_dwell: assert property (p_clear_after_dwell) else $error("flag cleared early");

   property p_hold_while_not_below;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (flag_r && i_enable && !below) |=> flag_r;
   endproperty
   a_hold_while_not_below: assert property (p_hold_while_not_below) else $error("flag dropped");

   property p_dwell_count;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (flag_r && below && !above && dwell_cnt_r < i_dwell && i_dwell == $past(i_dwell))
         |=> dwell_cnt_r == $past(dwell_cnt_r) + 1'b1;
   endproperty
   a_dwell_count: assert property (p_dwell_count) else $error("dwell count stalled");

endmodule // atpm_thresh_chan

// *** verilog/atpm_monitor.sv ***
// Top of the amplitude monitor: serial register port, magnitude, flags and peak monitor.
`timescale 1ns/1ps
module atpm_monitor (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Converter samples, two's complement, and decimated sample strobe
   input wire logic [atpm_pkg::ATPM_SAMPLE_W-1:0] i_chan_a_sample,
   input wire logic [atpm_pkg::ATPM_SAMPLE_W-1:0] i_chan_b_sample,
   input wire logic i_dec_strobe,
   // Serial register port
   input wire logic i_spi_cs_b,
   input wire logic i_spi_sclk,
   input wire logic i_spi_sdio_in,
   output logic o_spi_sdio_out,
   output logic o_spi_sdio_oe_b,
   // Threshold flag pins
   output logic o_chan_a_threshold_pin,
   output logic o_chan_b_threshold_pin
);

   localparam int NC = atpm_pkg::ATPM_NUM_CHAN;
   localparam int MW = atpm_pkg::ATPM_MAG_W;
   localparam int PW = atpm_pkg::ATPM_PERIOD_W;

   // Full scale is two to the thirteenth; the single code that reaches it saturates.
   function automatic logic [MW-1:0] mag_of(input logic [atpm_pkg::ATPM_SAMPLE_W-1:0] s);
      logic [atpm_pkg::ATPM_SAMPLE_W-1:0] a;
      a = s[atpm_pkg::ATPM_SAMPLE_W-1] ? (~s + 1'b1) : s;
      if (a[atpm_pkg::ATPM_SAMPLE_W-1]) begin
         mag_of = {MW{1'b1}};
      end else begin
         mag_of = a[MW-1:0];
      end
   endfunction

   // ---------------- Serial port input synchronisers ----------------
   logic [2:0] cs_sync_r;
   logic [2:0] sclk_sync_r;
   logic [2:0] sdi_sync_r;
   logic cs_b_f_r;
   logic sclk_f_r;
   logic sdi_f_r;
   logic sclk_prev_r;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cs_sync_r <= 3'h7;
         sclk_sync_r <= 3'h0;
         sdi_sync_r <= 3'h0;
      end else begin
         cs_sync_r <= {cs_sync_r[1:0], i_spi_cs_b};
         sclk_sync_r <= {sclk_sync_r[1:0], i_spi_sclk};
         sdi_sync_r <= {sdi_sync_r[1:0], i_spi_sdio_in};
      end
   end

   // A pin level counts only once the second and third stages agree.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cs_b_f_r <= 1'b1;
         sclk_f_r <= 1'b0;
         sdi_f_r <= 1'b0;
         sclk_prev_r <= 1'b0;
      end else begin
         if (cs_sync_r[1] == cs_sync_r[2]) cs_b_f_r <= cs_sync_r[2];
         if (sclk_sync_r[1] == sclk_sync_r[2]) sclk_f_r <= sclk_sync_r[2];
         if (sdi_sync_r[1] == sdi_sync_r[2]) sdi_f_r <= sdi_sync_r[2];
         sclk_prev_r <= sclk_f_r;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   assign sclk_rise = !cs_b_f_r && sclk_f_r && !sclk_prev_r;
   assign sclk_fall = !cs_b_f_r && !sclk_f_r && sclk_prev_r;

   // ---------------- Serial frame engine ----------------
   atpm_pkg::atpm_spi_state_t spi_state_r;
   logic [3:0] bit_cnt_r;
   logic [15:0] shift_in_r;
   logic [14:0] addr_r;
   logic rd_r;
   logic [7:0] shift_out_r;
   logic sdo_oe_b_r;
   logic wr_r;
   logic [7:0] wr_data_r;
   logic [7:0] rd_data;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         spi_state_r <= atpm_pkg::ATPM_SPI_INSTR;
         bit_cnt_r <= 4'h0;
         shift_in_r <= 16'h0000;
         addr_r <= 15'h0000;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         wr_data_r <= 8'h00;
      end else begin
         wr_r <= 1'b0;
         if (cs_b_f_r) begin
            spi_state_r <= atpm_pkg::ATPM_SPI_INSTR;
            bit_cnt_r <= 4'h0;
         end else if (sclk_rise) begin
            shift_in_r <= {shift_in_r[14:0], sdi_f_r};
            bit_cnt_r <= bit_cnt_r + 1'b1;
            case (spi_state_r)
               atpm_pkg::ATPM_SPI_INSTR: begin
                  if (bit_cnt_r == atpm_pkg::ATPM_SPI_INSTR_LAST) begin
                     rd_r <= shift_in_r[14];
                     addr_r <= {shift_in_r[13:0], sdi_f_r};
                     bit_cnt_r <= 4'h0;
                     spi_state_r <= atpm_pkg::ATPM_SPI_DATA;
                  end
               end
               atpm_pkg::ATPM_SPI_DATA: begin
                  if (bit_cnt_r == atpm_pkg::ATPM_SPI_DATA_LAST) begin
                     wr_r <= !rd_r;
                     wr_data_r <= {shift_in_r[6:0], sdi_f_r};
                     spi_state_r <= atpm_pkg::ATPM_SPI_DONE;
                  end
               end
               default: begin
                  bit_cnt_r <= 4'h0;
               end
            endcase
         end
      end
   end

   // Read data is shifted out on falling edges so the master can sample on rising ones.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shift_out_r <= 8'h00;
         sdo_oe_b_r <= 1'b1;
      end else if (cs_b_f_r || spi_state_r != atpm_pkg::ATPM_SPI_DATA || !rd_r) begin
         sdo_oe_b_r <= 1'b1;
      end else if (sclk_fall) begin
         sdo_oe_b_r <= 1'b0;
         if (bit_cnt_r == 4'h0) begin
            shift_out_r <= rd_data;
         end else begin
            shift_out_r <= {shift_out_r[6:0], 1'b0};
         end
      end
   end

   assign o_spi_sdio_out = shift_out_r[7];
   assign o_spi_sdio_oe_b = sdo_oe_b_r;

   // ---------------- Register file ----------------
   logic [7:0] upper_threshold_low_r;
   logic [7:0] upper_threshold_high_r;
   logic [7:0] lower_threshold_low_r;
   logic [7:0] lower_threshold_high_r;
   logic [7:0] dwell_time_low_r;
   logic [7:0] dwell_time_high_r;
   logic [7:0] peak_monitor_control_r;
   logic [7:0] threshold_flag_control_r;
   logic [PW-1:0] monitor_period_value_r;
   logic [MW-1:0] hold_r [NC];

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         upper_threshold_low_r <= atpm_pkg::ATPM_RST_BYTE;
         upper_threshold_high_r <= atpm_pkg::ATPM_RST_BYTE;
         lower_threshold_low_r <= atpm_pkg::ATPM_RST_BYTE;
         lower_threshold_high_r <= atpm_pkg::ATPM_RST_BYTE;
         dwell_time_low_r <= atpm_pkg::ATPM_RST_DWELL_LO;
         dwell_time_high_r <= atpm_pkg::ATPM_RST_BYTE;
         peak_monitor_control_r <= atpm_pkg::ATPM_RST_BYTE;
         threshold_flag_control_r <= atpm_pkg::ATPM_RST_BYTE;
         monitor_period_value_r <= '0;
      end else if (wr_r) begin
         if (addr_r == atpm_pkg::ATPM_ADDR_UPPER_LO) begin
            upper_threshold_low_r <= wr_data_r;
         end else if (addr_r == atpm_pkg::ATPM_ADDR_UPPER_HI) begin
            upper_threshold_high_r <= {3'h0, wr_data_r[atpm_pkg::ATPM_HI_BYTE_W-1:0]};
         end else if (addr_r == atpm_pkg::ATPM_ADDR_LOWER_LO) begin
            lower_threshold_low_r <= wr_data_r;
         end else if (addr_r == atpm_pkg::ATPM_ADDR_LOWER_HI) begin
            lower_threshold_high_r <= {3'h0, wr_data_r[atpm_pkg::ATPM_HI_BYTE_W-1:0]};
         end else if (addr_r == atpm_pkg::ATPM_ADDR_DWELL_LO) begin
            dwell_time_low_r <= wr_data_r;
         end else if (addr_r == atpm_pkg::ATPM_ADDR_DWELL_HI) begin
            dwell_time_high_r <= wr_data_r;
         end else if (addr_r == atpm_pkg::ATPM_ADDR_PEAK_CTRL) begin
            peak_monitor_control_r <= wr_data_r;
         end else if (addr_r == atpm_pkg::ATPM_ADDR_PERIOD_0) begin
            monitor_period_value_r[7:0] <= wr_data_r;
         end else if (addr_r == atpm_pkg::ATPM_ADDR_PERIOD_1) begin
            monitor_period_value_r[15:8] <= wr_data_r;
         end else if (addr_r == atpm_pkg::ATPM_ADDR_PERIOD_2) begin
            monitor_period_value_r[23:16] <= wr_data_r;
         end else if (addr_r == atpm_pkg::ATPM_ADDR_FLAG_CTRL) begin
            threshold_flag_control_r <= wr_data_r;
         end
      end
   end

   always_comb begin
      rd_data = 8'h00;
      if (addr_r == atpm_pkg::ATPM_ADDR_UPPER_LO) begin
         rd_data = upper_threshold_low_r;
      end else if (addr_r == atpm_pkg::ATPM_ADDR_UPPER_HI) begin
         rd_data = upper_threshold_high_r;
      end else if (addr_r == atpm_pkg::ATPM_ADDR_LOWER_LO) begin
         rd_data = lower_threshold_low_r;
      end else if (addr_r == atpm_pkg::ATPM_ADDR_LOWER_HI) begin
         rd_data = lower_threshold_high_r;
      end else if (addr_r == atpm_pkg::ATPM_ADDR_DWELL_LO) begin
         rd_data = dwell_time_low_r;
      end else if (addr_r == atpm_pkg::ATPM_ADDR_DWELL_HI) begin
         rd_data = dwell_time_high_r;
      end else if (addr_r == atpm_pkg::ATPM_ADDR_PEAK_CTRL) begin
         rd_data = peak_monitor_control_r;
      end else if (addr_r == atpm_pkg::ATPM_ADDR_PERIOD_0) begin
         rd_data = monitor_period_value_r[7:0];
      end else if (addr_r == atpm_pkg::ATPM_ADDR_PERIOD_1) begin
         rd_data = monitor_period_value_r[15:8];
      end else if (addr_r == atpm_pkg::ATPM_ADDR_PERIOD_2) begin
         rd_data = monitor_period_value_r[23:16];
      end else if (addr_r == atpm_pkg::ATPM_ADDR_HOLD_A_LO) begin
         rd_data = hold_r[0][7:0];
      end else if (addr_r == atpm_pkg::ATPM_ADDR_HOLD_A_HI) begin
         rd_data = {3'h0, hold_r[0][MW-1:8]};
      end else if (addr_r == atpm_pkg::ATPM_ADDR_HOLD_B_LO) begin
         rd_data = hold_r[1][7:0];
      end else if (addr_r == atpm_pkg::ATPM_ADDR_HOLD_B_HI) begin
         rd_data = {3'h0, hold_r[1][MW-1:8]};
      end else if (addr_r == atpm_pkg::ATPM_ADDR_FLAG_CTRL) begin
         rd_data = threshold_flag_control_r;
      end
   end

   logic [MW-1:0] upper_thr;
   logic [MW-1:0] lower_thr;
   logic [atpm_pkg::ATPM_DWELL_W-1:0] dwell;
   logic [NC-1:0] flag_en;
   logic peak_en;
   assign upper_thr = {upper_threshold_high_r[atpm_pkg::ATPM_HI_BYTE_W-1:0],
                       upper_threshold_low_r};
   assign lower_thr = {lower_threshold_high_r[atpm_pkg::ATPM_HI_BYTE_W-1:0],
                       lower_threshold_low_r};
   assign dwell = {dwell_time_high_r, dwell_time_low_r};
   assign flag_en = {threshold_flag_control_r[atpm_pkg::ATPM_FLAG_EN_B_BIT],
                     threshold_flag_control_r[atpm_pkg::ATPM_FLAG_EN_A_BIT]};
   assign peak_en = peak_monitor_control_r[atpm_pkg::ATPM_PEAK_EN_BIT];

   // ---------------- Magnitude and threshold channels ----------------
   logic [MW-1:0] mag_r [NC];
   logic strobe_r;
   logic [NC-1:0] flag;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mag_r[0] <= '0;
         mag_r[1] <= '0;
         strobe_r <= 1'b0;
      end else begin
         mag_r[0] <= mag_of(i_chan_a_sample);
         mag_r[1] <= mag_of(i_chan_b_sample);
         strobe_r <= i_dec_strobe;
      end
   end

   for (genvar c = 0; c < NC; c++) begin : g_chan
      atpm_thresh_chan u_thresh (
         .i_ref_clk(i_ref_clk),
         .i_rst_b(i_rst_b),
         .i_mag(mag_r[c]),
         .i_enable(flag_en[c]),
         .i_upper(upper_thr),
         .i_lower(lower_thr),
         .i_dwell(dwell),
         .o_flag(flag[c])
      );
   end

   assign o_chan_a_threshold_pin = flag[0];
   assign o_chan_b_threshold_pin = flag[1];

   // ---------------- Peak monitor ----------------
   logic peak_en_d_r;
   logic peak_en_rise;
   logic [PW-1:0] timer_r;
   logic seed_r;
   logic period_end;
   logic [MW-1:0] store_r [NC];

   assign peak_en_rise = peak_en && !peak_en_d_r;
   assign period_end = peak_en && !peak_en_rise && strobe_r && timer_r <= 24'h000001;

   // The period is sampled at enable and again at each period end, so it must be written before enable.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         peak_en_d_r <= 1'b0;
         timer_r <= '0;
      end else begin
         peak_en_d_r <= peak_en;
         if (!peak_en) begin
            timer_r <= '0;
         end else if (peak_en_rise) begin
            timer_r <= monitor_period_value_r;
         end else if (period_end) begin
            timer_r <= monitor_period_value_r;
         end else if (strobe_r) begin
            timer_r <= timer_r - 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         seed_r <= 1'b0;
      end else if (!peak_en || peak_en_rise || period_end) begin
         seed_r <= 1'b1;
      end else if (strobe_r) begin
         seed_r <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         store_r[0] <= '0;
         store_r[1] <= '0;
         hold_r[0] <= '0;
         hold_r[1] <= '0;
      end else if (peak_en && !peak_en_rise && strobe_r) begin
         for (int c = 0; c < NC; c++) begin
            if (seed_r) begin
               store_r[c] <= mag_r[c];
            end else if (mag_r[c] > store_r[c]) begin
               store_r[c] <= mag_r[c];
            end
            if (period_end) begin
               hold_r[c] <= (seed_r || mag_r[c] > store_r[c]) ? mag_r[c] : store_r[c];
            end
         end
      end
   end

   // ---------------- Checks ----------------
   sequence s_over_a;
      flag_en[0] && (mag_of(i_chan_a_sample) > upper_thr);
   endsequence

   property p_upper_latency;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_over_a ##1 flag_en[0] |-> ##1 o_chan_a_threshold_pin;
   endproperty
   a_upper_latency: assert property (p_upper_latency) else $error("flag pin late");

   property p_pin_off_when_disabled;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      !flag_en[1] |=> !o_chan_b_threshold_pin;
   endproperty
   a_pin_off_when_disabled: assert property (p_pin_off_when_disabled)
      else $error("flag pin high while disabled");

   property p_timer_load;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      peak_en_rise |=> timer_r == $past(monitor_period_value_r);
   endproperty
   a_timer_load: assert property (p_timer_load) else $error("timer not loaded");

   property p_transfer;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      period_end |=> (timer_r == $past(monitor_period_value_r)) && seed_r
                     && hold_r[0] >= $past(mag_r[0]);
   endproperty
   a_transfer: assert property (p_transfer) else $error("period end mishandled");

   property p_store_max;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (peak_en && !peak_en_rise && strobe_r && !seed_r)
         |=> store_r[0] >= $past(mag_r[0]) && store_r[0] >= $past(store_r[0]);
   endproperty
   a_store_max: assert property (p_store_max) else $error("store lost the peak");

   property p_seed;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (peak_en && !peak_en_rise && strobe_r && seed_r) |=> store_r[1] == $past(mag_r[1]);
   endproperty
   a_seed: assert property (p_seed) else $error("store not seeded");

   property p_no_transfer_disabled;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      !peak_en |=> $stable(hold_r[0]) && $stable(hold_r[1]);
   endproperty
   a_no_transfer_disabled: assert property (p_no_transfer_disabled)
      else $error("hold changed while disabled");

   property p_sdio_drive_read_only;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      !o_spi_sdio_oe_b |-> $past(rd_r) && !$past(cs_b_f_r);
   endproperty
   a_sdio_drive_read_only: assert property (p_sdio_drive_read_only)
      else $error("data pin driven outside read");

endmodule // atpm_monitor

// *** tb/atpm_agc_model.sv ***
// Stand-in for the gain control logic that counts flag assertions per channel.
`timescale 1ns/1ps
module atpm_agc_model (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Flag pins
   input wire logic i_flag_a,
   input wire logic i_flag_b,
   // Rise counts
   output logic [7:0] o_rise_a,
   output logic [7:0] o_rise_b
);
   logic [1:0] last_r;
   // Each pin is watched on its own, so a flag on one channel never counts for the other.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         last_r <= 2'h0;
         o_rise_a <= 8'h00;
         o_rise_b <= 8'h00;
      end else begin
         last_r <= {i_flag_b, i_flag_a};
         o_rise_a <= o_rise_a + 8'(i_flag_a & ~last_r[0]);
         o_rise_b <= o_rise_b + 8'(i_flag_b & ~last_r[1]);
      end
   end
endmodule // atpm_agc_model

// *** tb/tb_top.sv ***
// Self-checking bench for the amplitude threshold and peak monitor.
`timescale 1ns/1ps
module tb_top;
   logic clk = 0, rst_b = 0, st = 0, cs_b = 1, sclk = 0, sdi = 0, sdo, oe_b, fa, fb, ol;
   logic [13:0] sa = 14'h0000, sb = 14'h0000, va, vb;
   logic [7:0] ra, rb, q;
   logic [12:0] ma, mb;
   int errors = 0, check_count = 0, seed = 26;
   atpm_monitor u_atpm_monitor (.i_ref_clk(clk), .i_rst_b(rst_b), .i_chan_a_sample(sa),
      .i_chan_b_sample(sb), .i_dec_strobe(st), .i_spi_cs_b(cs_b), .i_spi_sclk(sclk),
      .i_spi_sdio_in(sdi), .o_spi_sdio_out(sdo), .o_spi_sdio_oe_b(oe_b),
      .o_chan_a_threshold_pin(fa), .o_chan_b_threshold_pin(fb));
   atpm_agc_model u_atpm_agc_model (.i_ref_clk(clk), .i_rst_b(rst_b), .i_flag_a(fa),
      .i_flag_b(fb), .o_rise_a(ra), .o_rise_b(rb));
   initial forever #2.5 clk = ~clk;
   task stop_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", n, e, s);
      end
   endtask
   // Each sclk phase lasts 8 reference cycles to clear the pin synchronisers.
   task spi(input logic rw, input logic [14:0] a, input logic [7:0] d);
      logic [23:0] f;
      f = {rw, a, d};
      @(posedge clk);
      cs_b <= 1'b0;
      repeat (8) @(posedge clk);
      for (int i = 23; i >= 0; i--) begin
         sdi <= f[i];
         sclk <= 1'b0;
         repeat (8) @(posedge clk);
         if (i < 8) q[i] = sdo;
         if (i == 0) ol = oe_b;
         sclk <= 1'b1;
         repeat (8) @(posedge clk);
      end
      sclk <= 1'b0;
      repeat (8) @(posedge clk);
      cs_b <= 1'b1;
      repeat (16) @(posedge clk);
   endtask
   function automatic logic [12:0] mag(input logic [13:0] s);
      if (s == 14'h2000) return 13'h1FFF;
      return s[13] ? 13'(-s) : s[12:0];
   endfunction
   task strobe(input logic [13:0] a, input logic [13:0] b);
      sa <= a;
      sb <= b;
      st <= 1'b1;
      @(posedge clk);
      st <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // Inputs change on an edge; the flag is looked at 1 ns after the last edge, once settled.
   task samp(input logic [13:0] a, input logic [13:0] b, input int n);
      @(posedge clk);
      sa <= a;
      sb <= b;
      repeat (n) @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge clk);
      spi(1, 15'h024B, 8'h00);
      chk("dwell_lo", 16'h0001, {8'h00, q});
      chk("oe_read", 16'h0000, {15'h0000, ol});
      chk("oe_idle", 16'h0001, {15'h0000, oe_b});
      spi(1, 15'h0100, 8'h00);
      chk("unmapped", 16'h0000, {8'h00, q});
      spi(0, 15'h0248, 8'hFF);
      spi(1, 15'h0248, 8'h00);
      chk("upper_hi", 16'h001F, {8'h00, q});
      spi(0, 15'h0248, 8'h00);
      spi(0, 15'h0247, 8'h64);
      spi(0, 15'h0249, 8'h32);
      spi(0, 15'h024B, 8'h03);
      spi(0, 15'h0559, 8'h03);
      samp(14'h0064, 14'h0000, 3);
      chk("equal_upper", 16'h0000, {15'h0000, fa});
      samp(14'h3F9B, 14'h0000, 2);
      chk("set_a", 16'h0001, {15'h0000, fa});
      chk("b_quiet", 16'h0000, {15'h0000, fb});
      samp(14'h003C, 14'h0000, 20);
      chk("hyst", 16'h0001, {15'h0000, fa});
      samp(14'h000A, 14'h0000, 4);
      chk("dwell_hold", 16'h0001, {15'h0000, fa});
      samp(14'h000A, 14'h0000, 1);
      chk("clear_a", 16'h0000, {15'h0000, fa});
      samp(14'h000A, 14'h3F9B, 3);
      chk("set_b", 16'h0001, {15'h0000, fb});
      spi(0, 15'h0559, 8'h01);
      chk("off_b", 16'h0000, {15'h0000, fb});
      chk("rises_a", 16'h0001, {8'h00, ra});
      chk("rises_b", 16'h0001, {8'h00, rb});
      spi(0, 15'h0271, 8'h03);
      spi(0, 15'h0270, 8'h02);
      for (int p = 0; p < 2; p++) begin
         ma = 13'h0000;
         mb = 13'h0000;
         for (int k = 0; k < 3; k++) begin
            va = 14'($random(seed));
            vb = 14'($random(seed));
            if (p == 1 && k == 0) va = 14'h2000;
            if (mag(va) > ma) ma = mag(va);
            if (mag(vb) > mb) mb = mag(vb);
            strobe(va, vb);
         end
         spi(1, 15'h0274, 8'h00);
         chk("hold_a_lo", {8'h00, ma[7:0]}, {8'h00, q});
         spi(1, 15'h0275, 8'h00);
         chk("hold_a_hi", {11'h000, ma[12:8]}, {8'h00, q});
         spi(1, 15'h0276, 8'h00);
         chk("hold_b_lo", {8'h00, mb[7:0]}, {8'h00, q});
         spi(1, 15'h0277, 8'h00);
         chk("hold_b_hi", {11'h000, mb[12:8]}, {8'h00, q});
      end
      stop_test;
   end
endmodule // tb_top
